// ### pced_pkg.sv
package pced_pkg;
   // number of pin slots held by this block, reference numbers 1 to NPIN
   localparam int          NPIN        = 4;
   localparam logic [4:0]  REF_MAX     = 5'h04;
   // register byte addresses
   localparam logic [7:0]  ADDR_CMD    = 8'h00;
   localparam logic [7:0]  ADDR_DAT0   = 8'h04;
   localparam logic [7:0]  ADDR_DAT1   = 8'h08;
   localparam logic [7:0]  ADDR_DAT2   = 8'h0C;
   localparam logic [7:0]  ADDR_DAT3   = 8'h10;
   localparam logic [7:0]  ADDR_STAT   = 8'h14;
   localparam logic [7:0]  ADDR_PSTAT  = 8'h18;
   localparam logic [7:0]  ADDR_PROV   = 8'h1C;
   // command word fields
   localparam int          CMD_P1_LSB  = 0;
   localparam int          CMD_P2_LSB  = 8;
   localparam int          CMD_LC_LSB  = 16;
   localparam int          CMD_OP_LSB  = 24;
   // status and pin status fields
   localparam int          STAT_BUSY   = 16;
   localparam int          PST_EN      = 2;
   localparam int          PST_BLK     = 3;
   localparam int          PST_REF_LSB = 4;
   localparam int          PST_Q_LSB   = 16;
   // operation codes in the command word
   localparam logic [1:0]  OP_CHANGE   = 2'h1;
   localparam logic [1:0]  OP_DISABLE  = 2'h2;
   localparam logic [1:0]  OP_ENABLE   = 2'h3;
   // command coding
   localparam logic [7:0]  LC_CHANGE   = 8'h10;
   localparam logic [7:0]  LC_PIN      = 8'h08;
   localparam logic [7:0]  P1_PLAIN    = 8'h00;
   localparam logic [7:0]  QUAL_USE    = 8'h08;
   localparam logic [7:0]  QUAL_OFF    = 8'h00;
   // status words
   localparam logic [15:0] SW_OK       = 16'h9000;
   localparam logic [11:0] SW_TRIES    = 12'h63C;
   localparam logic [15:0] SW_BLOCKED  = 16'h6983;
   localparam logic [15:0] SW_COND     = 16'h6985;
   localparam logic [15:0] SW_LEN      = 16'h6700;
   localparam logic [15:0] SW_P1P2     = 16'h6B00;
   localparam logic [15:0] SW_NOREF    = 16'h6A88;
   // reset values, and the enabled flag written when a pin blocks
   localparam logic [1:0]  TRIES_INIT  = 2'h3;
   localparam logic [63:0] PIN_RESET   = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic        EN_RESET    = 1'b1;
   localparam logic        EN_ON_BLOCK = 1'b0;

   typedef enum logic {ST_IDLE, ST_EXEC} pced_state_t;
endpackage : pced_pkg

// ### pced_top.sv
// Overview of operation
// - Change with correct old pin: tries back to 3, new pin stored.
// - Change with wrong old pin: tries decrement, stored pin kept.
// - Three wrong tries in a row block the pin until unblocked.
// - A changed pin is one shared value, valid on every channel at once.
// - Change only runs on an enabled, unblocked pin.
// - Disable with correct pin: tries back to 3, enabled flag cleared.
// - Disable with wrong pin: tries decrement, pin stays enabled.
// - Disable of an already disabled or blocked pin is refused.
// - Disabled pin frees its files, or hands them to the replacement key.
// - Files citing several keys are free once one cited key is disabled.
// - Disable P1: 00 plain, 01 reserved, b8 set gives replacement key.
// - Chosen replacement key gets usage qualifier 08.
// - Each successful disable or enable re-evaluates the access context.
// - Enable with correct pin: tries back to 3, enabled flag set.
// - Enable with wrong pin: tries decrement, pin stays disabled.
// - Enable of an already enabled or blocked pin is refused.
// - Enabling ends a replacement by writing qualifier 00.
// - Blocked and disabled stays open; blocked and enabled stays shut.
// - P2 b8 picks global or specific, b5 to b1 the reference number.
// - Wrong pin answers 63CX with X the tries left.
`timescale 1ns/1ps
`default_nettype none

module pced_top (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata_ff,
   output logic                           pready_ff,
   output logic                           pslverr_ff,
   input  wire logic [pced_pkg::NPIN-1:0] file_refs,
   output logic      [pced_pkg::NPIN-1:0] pin_free_ff,
   output logic      [pced_pkg::NPIN-1:0] alt_req_ff,
   output logic                           file_always_ff,
   output logic                           ctx_reval_ff,
   output logic                           done_ff
);

   localparam int N = pced_pkg::NPIN;

   pced_pkg::pced_state_t state_ff;

   logic [31:0] cmd_ff;
   logic [31:0] dat_ff [4];
   logic [15:0] sw_ff;
   logic [1:0]  last_slot_ff;

   logic [63:0] pin_ff   [N];
   logic [1:0]  tries_ff [N];
   logic        en_ff    [N];
   logic [4:0]  repl_ff  [N];
   logic [7:0]  qual_ff  [N];

   logic        setup;
   logic        wr_acc;
   logic        mapped;
   logic [31:0] nxt_rdata;

   logic [7:0]  p1;
   logic [7:0]  p2;
   logic [7:0]  lc;
   logic [1:0]  op;
   logic [4:0]  ref_idx;
   logic [1:0]  slot;
   logic        ref_ok;
   logic        p1_ok;
   logic        lc_ok;
   logic        cond_ok;
   logic        match;
   logic        apply_ok;
   logic        wrong;
   logic [1:0]  dec_tries;
   logic [15:0] nxt_sw;
   logic [63:0] old_pin;
   logic [63:0] new_pin;

   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && pready_ff;

   // apb slave: one wait-free access phase after each setup cycle
   always_comb
   begin
      mapped    = (paddr[1:0] == 2'h0);
      nxt_rdata = 32'h0000_0000;
      case (paddr)
         pced_pkg::ADDR_CMD:   nxt_rdata = cmd_ff;
         pced_pkg::ADDR_DAT0:  nxt_rdata = dat_ff[0];
         pced_pkg::ADDR_DAT1:  nxt_rdata = dat_ff[1];
         pced_pkg::ADDR_DAT2:  nxt_rdata = dat_ff[2];
         pced_pkg::ADDR_DAT3:  nxt_rdata = dat_ff[3];
         pced_pkg::ADDR_STAT:
         begin
            nxt_rdata[15:0] = sw_ff;
            nxt_rdata[pced_pkg::STAT_BUSY] =
               (state_ff != pced_pkg::ST_IDLE);
         end
         pced_pkg::ADDR_PSTAT:
         begin
            nxt_rdata[1:0] = tries_ff[last_slot_ff];
            nxt_rdata[pced_pkg::PST_EN] = en_ff[last_slot_ff];
            nxt_rdata[pced_pkg::PST_BLK] =
               (tries_ff[last_slot_ff] == 2'h0);
            nxt_rdata[pced_pkg::PST_REF_LSB +: 5] =
               repl_ff[last_slot_ff];
            nxt_rdata[pced_pkg::PST_Q_LSB +: 8] = qual_ff[last_slot_ff];
         end
         pced_pkg::ADDR_PROV:  nxt_rdata = 32'h0000_0000;
         default:              mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !mapped;
         if (setup && !pwrite && mapped)
         begin
            prdata_ff <= nxt_rdata;
         end
         else if (setup)
         begin
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   // command and data staging; a cmd write launches one execution
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_ff    <= 32'h0000_0000;
         dat_ff[0] <= 32'h0000_0000;
         dat_ff[1] <= 32'h0000_0000;
         dat_ff[2] <= 32'h0000_0000;
         dat_ff[3] <= 32'h0000_0000;
      end
      else if (wr_acc && !pslverr_ff)
      begin
         case (paddr)
            pced_pkg::ADDR_CMD:  cmd_ff    <= pwdata;
            pced_pkg::ADDR_DAT0: dat_ff[0] <= pwdata;
            pced_pkg::ADDR_DAT1: dat_ff[1] <= pwdata;
            pced_pkg::ADDR_DAT2: dat_ff[2] <= pwdata;
            pced_pkg::ADDR_DAT3: dat_ff[3] <= pwdata;
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= pced_pkg::ST_IDLE;
      end
      else
      begin
         case (state_ff)
            pced_pkg::ST_IDLE:
            begin
               if (wr_acc && !pslverr_ff && paddr == pced_pkg::ADDR_CMD)
               begin
                  state_ff <= pced_pkg::ST_EXEC;
               end
            end
            pced_pkg::ST_EXEC: state_ff <= pced_pkg::ST_IDLE;
            default:           state_ff <= pced_pkg::ST_IDLE;
         endcase
      end
   end

   // command decode and verdict, evaluated in the execute cycle
   always_comb
   begin
      p1       = cmd_ff[pced_pkg::CMD_P1_LSB +: 8];
      p2       = cmd_ff[pced_pkg::CMD_P2_LSB +: 8];
      lc       = cmd_ff[pced_pkg::CMD_LC_LSB +: 8];
      op       = cmd_ff[pced_pkg::CMD_OP_LSB +: 2];
      old_pin  = {dat_ff[1], dat_ff[0]};
      new_pin  = {dat_ff[3], dat_ff[2]};
      // b8 of P2 only picks the pin family; slots are keyed by number
      ref_idx  = p2[4:0] - 5'h01;
      slot     = ref_idx[1:0];
      ref_ok   = (p2[6:5] == 2'h0) && (p2[4:0] != 5'h00)
                 && (p2[4:0] <= pced_pkg::REF_MAX);
      lc_ok    = (op == pced_pkg::OP_CHANGE)
                 ? (lc == pced_pkg::LC_CHANGE)
                 : (lc == pced_pkg::LC_PIN);
      p1_ok    = (p1 == pced_pkg::P1_PLAIN);
      if (op == pced_pkg::OP_DISABLE && p1[7])
      begin
         p1_ok = (p1[6:5] == 2'h0) && (p1[4:0] != 5'h00);
      end
      cond_ok  = (op == pced_pkg::OP_ENABLE) ? !en_ff[slot]
                                             : en_ff[slot];
      match    = (old_pin == pin_ff[slot]);
      dec_tries = tries_ff[slot] - 2'h1;
      apply_ok = 1'b0;
      wrong    = 1'b0;
      nxt_sw   = pced_pkg::SW_OK;
      if (op == 2'h0)
      begin
         nxt_sw = pced_pkg::SW_P1P2;
      end
      else if (!lc_ok)
      begin
         nxt_sw = pced_pkg::SW_LEN;
      end
      else if (!p1_ok)
      begin
         nxt_sw = pced_pkg::SW_P1P2;
      end
      else if (!ref_ok)
      begin
         nxt_sw = pced_pkg::SW_NOREF;
      end
      else if (tries_ff[slot] == 2'h0)
      begin
         nxt_sw = pced_pkg::SW_BLOCKED;
      end
      else if (!cond_ok)
      begin
         nxt_sw = pced_pkg::SW_COND;
      end
      else if (match)
      begin
         apply_ok = 1'b1;
      end
      else
      begin
         wrong  = 1'b1;
         nxt_sw = {pced_pkg::SW_TRIES, 2'h0, dec_tries};
      end
   end

   // single pin store shared by every logical channel
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < N; i++)
         begin
            pin_ff[i]   <= pced_pkg::PIN_RESET;
            tries_ff[i] <= pced_pkg::TRIES_INIT;
            en_ff[i]    <= pced_pkg::EN_RESET;
            repl_ff[i]  <= 5'h00;
            qual_ff[i]  <= pced_pkg::QUAL_OFF;
         end
      end
      else if (state_ff == pced_pkg::ST_EXEC)
      begin
         if (apply_ok)
         begin
            tries_ff[slot] <= pced_pkg::TRIES_INIT;
            case (op)
               pced_pkg::OP_CHANGE:
               begin
                  pin_ff[slot] <= new_pin;
               end
               pced_pkg::OP_DISABLE:
               begin
                  en_ff[slot] <= 1'b0;
                  if (p1[7])
                  begin
                     repl_ff[slot] <= p1[4:0];
                     qual_ff[slot] <= pced_pkg::QUAL_USE;
                  end
               end
               pced_pkg::OP_ENABLE:
               begin
                  en_ff[slot] <= 1'b1;
                  if (qual_ff[slot] == pced_pkg::QUAL_USE)
                  begin
                     qual_ff[slot] <= pced_pkg::QUAL_OFF;
                  end
               end
               default:
               begin
               end
            endcase
         end
         else if (wrong)
         begin
            // pin value and enabled flag are left as they were
            tries_ff[slot] <= dec_tries;
            if (op == pced_pkg::OP_ENABLE && dec_tries == 2'h0)
            begin
               en_ff[slot] <= pced_pkg::EN_ON_BLOCK;
            end
         end
      end
      else if (wr_acc && !pslverr_ff && paddr == pced_pkg::ADDR_PROV)
      begin
         // personalisation: load a slot with the pin in data bytes 1..8
         pin_ff[pwdata[1:0]]   <= {dat_ff[1], dat_ff[0]};
         tries_ff[pwdata[1:0]] <= pced_pkg::TRIES_INIT;
         en_ff[pwdata[1:0]]    <= pced_pkg::EN_RESET;
         repl_ff[pwdata[1:0]]  <= 5'h00;
         qual_ff[pwdata[1:0]]  <= pced_pkg::QUAL_OFF;
      end
   end

   // exactly one status word per launched request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sw_ff        <= pced_pkg::SW_OK;
         last_slot_ff <= 2'h0;
         done_ff      <= 1'b0;
         ctx_reval_ff <= 1'b0;
      end
      else
      begin
         done_ff      <= (state_ff == pced_pkg::ST_EXEC);
         ctx_reval_ff <= (state_ff == pced_pkg::ST_EXEC) && apply_ok
                         && (op != pced_pkg::OP_CHANGE);
         if (state_ff == pced_pkg::ST_EXEC)
         begin
            sw_ff <= nxt_sw;
            if (ref_ok)
            begin
               last_slot_ff <= slot;
            end
         end
      end
   end

   // access view; blocked pins keep whatever their enabled flag says
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_free_ff    <= '0;
         alt_req_ff     <= '0;
         file_always_ff <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            pin_free_ff[i] <= !en_ff[i]
                              && (qual_ff[i] != pced_pkg::QUAL_USE);
            alt_req_ff[i]  <= !en_ff[i]
                              && (qual_ff[i] == pced_pkg::QUAL_USE);
         end
         file_always_ff <= multi_ref(file_refs)
                           && ((file_refs & ~en_vec()) != '0);
      end
   end

   function automatic logic multi_ref(input logic [N-1:0] m);
      logic [3:0] cnt;
      cnt = 4'h0;
      for (int i = 0; i < N; i++)
      begin
         cnt = cnt + {3'h0, m[i]};
      end
      return cnt > 4'h1;
   endfunction : multi_ref

   function automatic logic [N-1:0] en_vec();
      logic [N-1:0] v;
      for (int i = 0; i < N; i++)
      begin
         v[i] = en_ff[i];
      end
      return v;
   endfunction : en_vec

endmodule : pced_top

`default_nettype wire

// ### pced_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module pced_asserts (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic                      pready_ff,
   input wire logic                      pslverr_ff,
   input wire logic [pced_pkg::NPIN-1:0] file_refs,
   input wire logic [pced_pkg::NPIN-1:0] pin_free_ff,
   input wire logic [pced_pkg::NPIN-1:0] alt_req_ff,
   input wire logic                      file_always_ff,
   input wire logic                      ctx_reval_ff,
   input wire logic                      done_ff
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_setup: assert property (psel && !penable |=> pready_ff)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready_ff |=> !pready_ff)
      else $error("ready held too long");
   a_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'h0
      |=> pslverr_ff)
      else $error("misaligned access not refused");
   a_err_mapped: assert property (psel && !penable && paddr[1:0] == 2'h0
      && paddr <= pced_pkg::ADDR_PROV |=> !pslverr_ff)
      else $error("mapped access refused");
   a_err_unmapped: assert property (psel && !penable
      && paddr > pced_pkg::ADDR_PROV |=> pslverr_ff)
      else $error("unmapped access not refused");
   a_cmd_done: assert property (psel && penable && pready_ff && pwrite
      && paddr == pced_pkg::ADDR_CMD |-> ##2 done_ff)
      else $error("command gave no status word");
   a_done_pulse: assert property (done_ff |=> !done_ff)
      else $error("status word reported twice");
   a_reval_done: assert property (ctx_reval_ff |-> done_ff)
      else $error("revalidation without completion");
   a_free_alt: assert property ((pin_free_ff & alt_req_ff) == 4'h0)
      else $error("slot both free and replaced");
   a_always_multi: assert property (file_always_ff
      |-> $countones($past(file_refs)) > 1)
      else $error("always access with one cited key");
endmodule : pced_asserts

bind pced_top pced_asserts i_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pready_ff, .pslverr_ff, .file_refs, .pin_free_ff,
   .alt_req_ff, .file_always_ff, .ctx_reval_ff, .done_ff);

`default_nettype wire

// ### pced_term.sv
`timescale 1ns/1ps
`default_nettype none

module pced_term (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata_ff,
   input  wire logic        pready_ff
);
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // the request stands until ready is sampled, however long that takes
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: a slave that never answers ends in the bench timeout
      do @(posedge pclk); while (pready_ff !== 1'b1);
      rd = prdata_ff;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep the last value, or stale reuse hides
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : xfer

   // pin bytes go ahead of the command word that launches execution
   task send_cmd(input logic [31:0] cmd, input logic [63:0] o, n);
      logic [31:0] rd;
      xfer(1'b1, pced_pkg::ADDR_DAT0, o[31:0], rd);
      xfer(1'b1, pced_pkg::ADDR_DAT1, o[63:32], rd);
      xfer(1'b1, pced_pkg::ADDR_DAT2, n[31:0], rd);
      xfer(1'b1, pced_pkg::ADDR_DAT3, n[63:32], rd);
      xfer(1'b1, pced_pkg::ADDR_CMD, cmd, rd);
   endtask : send_cmd
endmodule : pced_term

`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                      pclk, presetn, psel, penable, pwrite;
   logic                      pready_ff, pslverr_ff, file_always_ff;
   logic                      ctx_reval_ff, done_ff;
   logic [7:0]                paddr;
   logic [31:0]               pwdata, prdata_ff, r;
   logic [pced_pkg::NPIN-1:0] file_refs, pin_free_ff, alt_req_ff;
   int                        miscompares, tests_run, cycles, i;
   // behavioural pin slots
   logic [63:0]               mp [4];
   int                        mt [4];
   bit                        me [4];
   logic [7:0]                mq [4];
   logic [4:0]                mr [4];
   logic [31:0]               bad [10] = '{32'h0208_0101, 32'h0208_01A1,
      32'h0208_0180, 32'h0108_0100, 32'h0310_0100, 32'h0308_0101,
      32'h0008_0100, 32'h0308_0500, 32'h0308_0000, 32'h0308_2100};

   pced_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata_ff, .pready_ff, .pslverr_ff, .file_refs,
      .pin_free_ff, .alt_req_ff, .file_always_ff, .ctx_reval_ff, .done_ff);
   pced_term i_term (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata_ff, .pready_ff);

   always #50 pclk = ~pclk;

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   task report_and_stop;
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task run(input logic [1:0] op, input logic [7:0] p1, p2, lc, input bit g);
      logic [63:0] o, n;
      logic [15:0] sw;
      logic [3:0]  fr, ar, en;
      int          s;
      bit          rv, ex;
      s = (int'(p2[2:0]) + 3) % 4;
      o = g ? mp[s] : ~mp[s];
      n = {$urandom, $urandom};
      ex = 1'b0;
      @(posedge pclk);
      file_refs <= 4'($urandom);
      i_term.send_cmd({6'h0, op, lc, p2, p1}, o, n);
      // a request that never completes is caught by the cycle timeout
      do @(negedge pclk); while (done_ff !== 1'b1);
      rv = ctx_reval_ff;
      if (lc != (op == 2'h1 ? pced_pkg::LC_CHANGE : pced_pkg::LC_PIN))
         sw = pced_pkg::SW_LEN;
      else if (op == 2'h0 || (op != pced_pkg::OP_DISABLE ? p1 != 8'h00 :
               !(p1 == 8'h00 || (p1[7] && p1[6:5] == 2'h0 && p1[4:0] != 0))))
         sw = pced_pkg::SW_P1P2;
      else if (p2[6:5] != 2'h0 || p2[4:0] == 5'h0 || p2[4:0] > 5'h04)
         sw = pced_pkg::SW_NOREF;
      else if (mt[s] == 0)
         sw = pced_pkg::SW_BLOCKED;
      else if (me[s] == (op == pced_pkg::OP_ENABLE))
         sw = pced_pkg::SW_COND;
      else if (o == mp[s])
      begin
         sw = pced_pkg::SW_OK;
         mt[s] = 3;
         ex = (op != pced_pkg::OP_CHANGE);
         if (op == pced_pkg::OP_CHANGE)
            mp[s] = n;
         if (op != pced_pkg::OP_CHANGE)
            me[s] = (op == pced_pkg::OP_ENABLE);
         if (op == pced_pkg::OP_ENABLE || p1[7])
            mq[s] = p1[7] ? pced_pkg::QUAL_USE : pced_pkg::QUAL_OFF;
         if (op == pced_pkg::OP_DISABLE && p1[7])
            mr[s] = p1[4:0];
      end
      else
      begin
         mt[s]--;
         sw = {pced_pkg::SW_TRIES, 4'(mt[s])};
      end
      i_term.xfer(1'b0, pced_pkg::ADDR_STAT, 32'h0, r);
      chk(r, {16'h0, sw});
      if (sw != pced_pkg::SW_LEN && sw != pced_pkg::SW_P1P2
          && sw != pced_pkg::SW_NOREF)
      begin
         i_term.xfer(1'b0, pced_pkg::ADDR_PSTAT, 32'h0, r);
         chk(r & 32'h00FF_01FF, {8'h0, mq[s], 7'h0, mr[s], mt[s] == 0,
             me[s], 2'(mt[s])});
      end
      for (int j = 0; j < 4; j++)
      begin
         en[j] = me[j];
         fr[j] = !me[j] && mq[j] != pced_pkg::QUAL_USE;
         ar[j] = !me[j] && mq[j] == pced_pkg::QUAL_USE;
      end
      chk({22'h0, pin_free_ff, alt_req_ff, file_always_ff, rv},
          {22'h0, fr, ar, $countones(file_refs) > 1 && (file_refs & ~en) != 0,
           ex});
   endtask : run

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      file_refs = 4'h0;
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      void'($urandom(89));
      for (i = 0; i < 4; i++)
      begin
         mp[i] = '1;
         mt[i] = 3;
         me[i] = 1'b1;
         mq[i] = 8'h00;
         mr[i] = 5'h00;
      end
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      i_term.xfer(1'b0, pced_pkg::ADDR_STAT, 32'h0, r);
      chk(r, {16'h0, pced_pkg::SW_OK});
      run(2'h1, 8'h00, 8'h01, 8'h10, 1'b1);
      run(2'h2, 8'h00, 8'h81, 8'h08, 1'b1);
      run(2'h2, 8'h00, 8'h01, 8'h08, 1'b1);
      run(2'h1, 8'h00, 8'h01, 8'h10, 1'b1);
      run(2'h3, 8'h00, 8'h01, 8'h08, 1'b0);
      run(2'h3, 8'h00, 8'h01, 8'h08, 1'b1);
      run(2'h3, 8'h00, 8'h01, 8'h08, 1'b1);
      for (i = 0; i < 4; i++)
         run(2'h1, 8'h00, 8'h02, 8'h10, 1'b0);
      run(2'h2, 8'h00, 8'h02, 8'h08, 1'b1);
      run(2'h3, 8'h00, 8'h02, 8'h08, 1'b1);
      run(2'h2, 8'h83, 8'h03, 8'h08, 1'b0);
      run(2'h2, 8'h83, 8'h03, 8'h08, 1'b1);
      run(2'h3, 8'h00, 8'h03, 8'h08, 1'b1);
      run(2'h2, 8'h00, 8'h04, 8'h08, 1'b1);
      for (i = 0; i < 3; i++)
         run(2'h3, 8'h00, 8'h04, 8'h08, 1'b0);
      for (i = 0; i < 10; i++)
         run(bad[i][25:24], bad[i][7:0], bad[i][15:8], bad[i][23:16],
             1'b1);
      // reprovisioning is the only local way out of a block
      mp[1] = {$urandom, $urandom};
      mt[1] = 3;
      i_term.xfer(1'b1, pced_pkg::ADDR_DAT0, mp[1][31:0], r);
      i_term.xfer(1'b1, pced_pkg::ADDR_DAT1, mp[1][63:32], r);
      i_term.xfer(1'b1, pced_pkg::ADDR_PROV, 32'h1, r);
      run(2'h1, 8'h00, 8'h02, 8'h10, 1'b1);
      i_term.xfer(1'b0, 8'h20, 32'h0, r);
      chk(r, 32'h0);
      i_term.xfer(1'b0, 8'h02, 32'h0, r);
      chk(r, 32'h0);
      report_and_stop();
   end
endmodule : testbench

`default_nettype wire
